// ==== dcs_apb_slave.sv ====
// APB slave front end: decode, write strobes and registered read data
`timescale 1ns/10ps
`include "dcs_regs.svh"
module dcs_apb_slave #(
    parameter int ADDR_W = 12
) (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire dcs_pkg::dcs_reg_t   clamp_rd,
    input  wire dcs_pkg::dcs_reg_t   sleep_rd,
    output logic                     wr_clamp,
    output logic                     wr_sleep,
    output dcs_pkg::dcs_reg_t        wdata
);

    logic [31:0] next_prdata;
    logic        hit_clamp;
    logic        hit_sleep;
    logic        access;

    initial begin
        if (ADDR_W < 10) begin
            $error("dcs_apb_slave address too narrow for the map");
        end
    end

    // Word-aligned match of one register index
    function automatic logic dcs_hit(input logic [ADDR_W-1:0] a,
                                     input logic [7:0]        idx);
        return a == ADDR_W'({idx, 2'b00});
    endfunction

    assign hit_clamp = dcs_hit(paddr, `DCS_CLAMP_IDX);
    assign hit_sleep = dcs_hit(paddr, `DCS_SLEEP_IDX);
    assign access    = psel && penable;
    assign pready    = 1'b1;
    assign pslverr   = access && !(hit_clamp || hit_sleep);
    assign wr_clamp  = access && pwrite && hit_clamp;
    assign wr_sleep  = access && pwrite && hit_sleep;
    assign wdata     = pwdata[15:0];

    // Read data captured in the setup cycle
    always_comb begin
        next_prdata = prdata;
        if (psel && !penable && !pwrite) begin
            if (hit_clamp) begin
                next_prdata = {16'h0000, clamp_rd};
            end else if (hit_sleep) begin
                next_prdata = {16'h0000, sleep_rd};
            end else begin
                next_prdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

endmodule // dcs_apb_slave

// ==== dcs_clamp_ctrl.sv ====
// Clamp and amplifier enable control under software and standby input
`timescale 1ns/10ps
`include "dcs_regs.svh"
module dcs_clamp_ctrl #(
    parameter int ADDR_W = 12,
    parameter int NUM_CH = 6
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              standby_input_a,
    output logic                   main_pair_a_hold,
    output logic                   main_pair_b_hold,
    output logic                   aux_out1_hold,
    output logic                   aux_out2_hold,
    output logic                   aux_out3_hold,
    output logic                   aux_out4_hold,
    output logic                   amp_enable_out
);

    initial begin
        if (NUM_CH != 6) begin
            $error("dcs_clamp_ctrl field layout serves six channels");
        end
    end

    // ------------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0]    hold;
    logic [NUM_CH-1:0]    next_hold;
    logic                 amp_enable_bit;
    logic                 next_amp_enable_bit;
    dcs_pkg::dcs_reg_t    sleep_cfg;
    dcs_pkg::dcs_reg_t    next_sleep_cfg;
    dcs_pkg::dcs_phase_t  phase;
    dcs_pkg::dcs_phase_t  next_phase;
    logic                 standby_s;
    logic                 wake_evt;
    logic                 wr_clamp;
    logic                 wr_sleep;
    dcs_pkg::dcs_reg_t    wdata;
    dcs_pkg::dcs_reg_t    clamp_rd;
    logic [NUM_CH-1:0]    standby_sel;
    logic [NUM_CH-1:0]    manual_wake;
    logic                 amp_follows_standby_a;
    logic                 amp_manual_wake_a;

    assign standby_sel           = sleep_cfg[`DCS_SEL_LSB +: NUM_CH];
    assign manual_wake           = sleep_cfg[`DCS_WAKE_LSB +: NUM_CH];
    assign amp_follows_standby_a = sleep_cfg[`DCS_AMP_SLEEP_BIT];
    assign amp_manual_wake_a     = sleep_cfg[`DCS_AMP_WAKE_BIT];

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    // Read back live state
    assign clamp_rd = dcs_pkg::dcs_reg_t'({amp_enable_bit, hold});

    dcs_apb_slave #(
        .ADDR_W (ADDR_W)
    ) u_apb (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .clamp_rd (clamp_rd),
        .sleep_rd (sleep_cfg),
        .wr_clamp (wr_clamp),
        .wr_sleep (wr_sleep),
        .wdata    (wdata)
    );

    // ------------------------------------------------------------------
    // Standby input synchroniser and phase
    // ------------------------------------------------------------------
    // Resync before use
    dcs_sync #(
        .STAGES (2)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       (standby_input_a),
        .q       (standby_s)
    );

    // Falling edge of the synchronised level wakes the channels
    always_comb begin
        next_phase = phase;
        wake_evt   = 1'b0;
        case (phase)
            dcs_pkg::DCS_AWAKE: begin
                if (standby_s) begin
                    next_phase = dcs_pkg::DCS_ASLEEP;
                end
            end
            dcs_pkg::DCS_ASLEEP: begin
                if (!standby_s) begin
                    next_phase = dcs_pkg::DCS_AWAKE;
                    wake_evt   = 1'b1;
                end
            end
            default: begin
                next_phase = dcs_pkg::DCS_AWAKE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            phase <= dcs_pkg::DCS_AWAKE;
        end else begin
            phase <= next_phase;
        end
    end

    // ------------------------------------------------------------------
    // Channel clamp bits
    // ------------------------------------------------------------------
    always_comb begin
        next_hold = hold;
        for (int i = 0; i < NUM_CH; i++) begin
            if (wake_evt && standby_sel[i] && !manual_wake[i]) begin
                next_hold[i] = 1'b0;
            end
            if (wr_clamp) begin
                next_hold[i] = wdata[`DCS_HOLD_LSB + i];
            end
            if (standby_s && standby_sel[i]) begin
                next_hold[i] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Amplifier enable
    // ------------------------------------------------------------------
    always_comb begin
        next_amp_enable_bit = amp_enable_bit;
        if (wake_evt && amp_follows_standby_a && !amp_manual_wake_a) begin
            next_amp_enable_bit = 1'b1;
        end
        if (wr_clamp) begin
            next_amp_enable_bit = wdata[`DCS_AMP_BIT];
        end
        if (amp_follows_standby_a && standby_s) begin
            next_amp_enable_bit = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Standby configuration
    // ------------------------------------------------------------------
    always_comb begin
        next_sleep_cfg = sleep_cfg;
        if (wr_sleep) begin
            next_sleep_cfg = wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            {amp_enable_bit, hold} <= `DCS_CLAMP_RST;
            sleep_cfg              <= `DCS_SLEEP_RST;
        end else begin
            hold           <= next_hold;
            amp_enable_bit <= next_amp_enable_bit;
            sleep_cfg      <= next_sleep_cfg;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Bit drives the pin
    assign amp_enable_out   = amp_enable_bit;
    // Channel order of the clamp bits
    assign main_pair_a_hold = hold[0];
    assign main_pair_b_hold = hold[1];
    assign aux_out1_hold    = hold[2];
    assign aux_out2_hold    = hold[3];
    assign aux_out3_hold    = hold[4];
    assign aux_out4_hold    = hold[5];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_amp_write_drive: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        wr_clamp && !(amp_follows_standby_a && standby_s)
        |=> amp_enable_out == $past(wdata[`DCS_AMP_BIT]))
        else $error("amplifier output does not follow written bit");

    a_amp_read_live: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        psel && !penable && !pwrite && paddr == ADDR_W'({`DCS_CLAMP_IDX,
        2'b00}) |=> prdata[`DCS_AMP_BIT] == $past(amp_enable_out))
        else $error("amplifier bit read differs from output");

    a_hold_write: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        wr_clamp && !standby_s && !wake_evt
        |=> hold == $past(wdata[NUM_CH-1:0]))
        else $error("clamp outputs do not follow written bits");

    a_reset_values: assert property (@(posedge ref_clk)
        disable iff (1'b0)
        !rst_n |=> {amp_enable_bit, hold} == `DCS_CLAMP_RST
        && sleep_cfg == `DCS_SLEEP_RST)
        else $error("register reset value wrong");

    a_sleep_records: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        standby_s ##1 standby_s
        |-> (clamp_rd[NUM_CH-1:0] & $past(standby_sel))
        == $past(standby_sel))
        else $error("clamp bit not recorded while in standby");

    a_amp_sleep_off: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        amp_follows_standby_a && standby_s |=> !amp_enable_out)
        else $error("amplifier not off in standby");

    a_amp_ignores: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        !amp_follows_standby_a && !wr_clamp |=> $stable(amp_enable_out))
        else $error("amplifier changed without follow bit");

    a_amp_manual: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        wake_evt && amp_follows_standby_a && amp_manual_wake_a
        && !wr_clamp |=> !amp_enable_out)
        else $error("amplifier woke without software write");

    a_amp_direct: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        wake_evt && amp_follows_standby_a && !amp_manual_wake_a
        && !wr_clamp |=> amp_enable_out)
        else $error("amplifier did not wake directly");

    a_chan_forced: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        $rose(standby_s) && (standby_sel != '0)
        |=> (hold & $past(standby_sel)) == $past(standby_sel))
        else $error("selected channel not clamped by standby input");

    a_chan_ignores: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        !wr_clamp |=> ((hold ^ $past(hold)) & ~$past(standby_sel)) == '0)
        else $error("unselected channel moved by standby input");

    a_chan_wake: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        wake_evt && !wr_clamp |=>
        (hold & $past(standby_sel & ~manual_wake)) == '0
        && (hold & $past(standby_sel & manual_wake))
        == $past(standby_sel & manual_wake))
        else $error("channel wake does not match manual wake bits");

    a_sleep_write: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        wr_sleep |=> sleep_cfg == $past(wdata))
        else $error("standby config write lost");

    c_enter_standby: cover property (@(posedge ref_clk) disable iff (!rst_n)
        phase == dcs_pkg::DCS_AWAKE ##1 phase == dcs_pkg::DCS_ASLEEP);

    c_amp_manual: cover property (@(posedge ref_clk) disable iff (!rst_n)
        wake_evt && amp_follows_standby_a && amp_manual_wake_a
        ##[1:50] wr_clamp && wdata[`DCS_AMP_BIT]);

    c_chan_direct: cover property (@(posedge ref_clk) disable iff (!rst_n)
        wake_evt && ((standby_sel & ~manual_wake) != '0));

    c_bad_addr: cover property (@(posedge ref_clk) disable iff (!rst_n)
        pslverr);

endmodule // dcs_clamp_ctrl

// ==== dcs_clamp_ctrl_tb.sv ====
// Self-checking testbench for the clamp and amplifier enable control
`timescale 1ns/10ps
`include "dcs_regs.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    n_errors++; $display("mismatch at %0t: got %0h expected %0h", \
    $time, got, exp); end end
module dcs_clamp_ctrl_tb;
    logic        ref_clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        standby_input_a;
    logic        want_level;
    logic [5:0]  holds;
    logic        amp;
    logic        h0, h1, h2, h3, h4, h5;
    int          n_errors;
    int          n_compared;
    localparam logic [11:0] A_CLAMP = 12'({`DCS_CLAMP_IDX, 2'b00});
    localparam logic [11:0] A_SLEEP = 12'({`DCS_SLEEP_IDX, 2'b00});
    localparam logic [11:0] A_NONE  = 12'h064;

    assign holds = {h5, h4, h3, h2, h1, h0};

    dcs_clamp_ctrl dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .standby_input_a(standby_input_a), .main_pair_a_hold(h0),
        .main_pair_b_hold(h1), .aux_out1_hold(h2), .aux_out2_hold(h3),
        .aux_out3_hold(h4), .aux_out4_hold(h5), .amp_enable_out(amp));

    dcs_host_model #(.LAG(2)) host_u (
        .ref_clk(ref_clk), .want_level(want_level),
        .standby_input_a(standby_input_a));

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // Bus and pin tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [15:0] d, output logic [31:0] rd,
                       output logic err);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            n_errors++;
            report_and_stop();
        end
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d,
                      input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
        `CHK(err, exp_err)
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp,
                         input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 16'h0000, rd, err);
        `CHK(rd, exp)
        `CHK(err, exp_err)
    endtask

    task automatic outs(input logic [5:0] eh, input logic ea);
        `CHK(holds, eh)
        `CHK(amp, ea)
    endtask

    // Pin change; outputs sampled mid-cycle around the third edge
    task automatic pin_step(input logic lvl, input logic [5:0] oh,
                            input logic oa, input logic [5:0] nh,
                            input logic na);
        int i;
        want_level <= lvl;
        for (i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            if (standby_input_a === lvl) break;
        end
        if (i == 16) begin
            n_errors++;
            report_and_stop();
        end
        @(posedge ref_clk);
        @(negedge ref_clk);
        outs(oh, oa);
        @(negedge ref_clk);
        outs(nh, na);
        @(posedge ref_clk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        outs(6'h3F, 1'b0);
        rdchk(A_CLAMP, 32'h0000003F, 1'b0);
        rdchk(A_SLEEP, 32'h0000FF00, 1'b0);
    endtask

    task automatic t_software();
        for (int i = 0; i < 6; i++) begin
            wr(A_CLAMP, 16'(1 << i), 1'b0);
            outs(6'(1 << i), 1'b0);
        end
        wr(A_CLAMP, 16'hFFFF, 1'b0);
        outs(6'h3F, 1'b1);
        rdchk(A_CLAMP, 32'h0000007F, 1'b0);
        wr(A_CLAMP, 16'h0040, 1'b0);
        outs(6'h00, 1'b1);
        wr(A_SLEEP, 16'h1234, 1'b0);
        rdchk(A_SLEEP, 32'h00001234, 1'b0);
        wr(A_NONE, 16'hFFFF, 1'b1);
        rdchk(A_NONE, 32'h00000000, 1'b1);
        rdchk(A_CLAMP, 32'h00000040, 1'b0);
    endtask

    task automatic t_direct_wake();
        wr(A_SLEEP, 16'h0055, 1'b0);
        wr(A_CLAMP, 16'h0040, 1'b0);
        pin_step(1'b1, 6'h00, 1'b1, 6'h15, 1'b0);
        rdchk(A_CLAMP, 32'h00000015, 1'b0);
        pin_step(1'b0, 6'h15, 1'b0, 6'h00, 1'b1);
        rdchk(A_CLAMP, 32'h00000040, 1'b0);
    endtask

    task automatic t_manual_wake();
        wr(A_SLEEP, 16'h6A6B, 1'b0);
        wr(A_CLAMP, 16'h0040, 1'b0);
        pin_step(1'b1, 6'h00, 1'b1, 6'h2B, 1'b0);
        wr(A_CLAMP, 16'h0040, 1'b0);
        outs(6'h2B, 1'b0);
        pin_step(1'b0, 6'h2B, 1'b0, 6'h2A, 1'b0);
        rdchk(A_CLAMP, 32'h0000002A, 1'b0);
        wr(A_CLAMP, 16'h0040, 1'b0);
        outs(6'h00, 1'b1);
    endtask

    task automatic t_amp_ignores();
        wr(A_SLEEP, 16'h003F, 1'b0);
        wr(A_CLAMP, 16'h0040, 1'b0);
        pin_step(1'b1, 6'h00, 1'b1, 6'h3F, 1'b1);
        pin_step(1'b0, 6'h3F, 1'b1, 6'h00, 1'b1);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        n_errors = 0;
        n_compared = 0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        want_level = 1'b0;
        t_reset();
        t_software();
        t_direct_wake();
        t_manual_wake();
        t_amp_ignores();
        t_reset();
        report_and_stop();
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        n_errors++;
        report_and_stop();
    end
endmodule // dcs_clamp_ctrl_tb

// ==== dcs_host_model.sv ====
// Host-side model that drives the standby input pin
`timescale 1ns/10ps
module dcs_host_model #(
    parameter int LAG = 0
) (
    input  wire logic ref_clk,
    input  wire logic want_level,
    output logic      standby_input_a
);
    int unsigned wait_cnt;

    initial begin
        standby_input_a = 1'b0;
        wait_cnt = 0;
    end

    // ------------------------------------------------------------------
    // Pin follows the request on the edge LAG+1 cycles after it changes
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (want_level === standby_input_a) begin
            wait_cnt <= 0;
        end else if (wait_cnt >= LAG) begin
            standby_input_a <= want_level;
            wait_cnt <= 0;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule // dcs_host_model

// ==== dcs_pkg.sv ====
// Types shared by the clamp and sleep control block
package dcs_pkg;

    // Phase of the synchronised standby input
    typedef enum logic [1:0] {
        DCS_AWAKE  = 2'b01,
        DCS_ASLEEP = 2'b10
    } dcs_phase_t;

    typedef logic [15:0] dcs_reg_t;

endpackage

// ==== dcs_regs.svh ====
// Register indices, reset values and field positions of the clamp control
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define DCS_CLAMP_IDX     8'h17
`define DCS_SLEEP_IDX     8'h18

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DCS_CLAMP_RST     7'h3F
`define DCS_SLEEP_RST     16'hFF00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DCS_HOLD_LSB      0
`define DCS_AMP_BIT       6
`define DCS_SEL_LSB       0
`define DCS_AMP_SLEEP_BIT 6
`define DCS_WAKE_LSB      8
`define DCS_AMP_WAKE_BIT  14

`endif

// ==== dcs_sync.sv ====
// Two-stage synchroniser for the standby input pin
`timescale 1ns/10ps
module dcs_sync #(
    parameter int STAGES = 2
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);

    logic [STAGES-1:0] ff;
    logic [STAGES-1:0] next_ff;

    initial begin
        if (STAGES < 2) begin
            $error("dcs_sync needs at least two stages");
        end
    end

    always_comb begin
        next_ff = {ff[STAGES-2:0], d};
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ff <= '0;
        end else begin
            ff <= next_ff;
        end
    end

    assign q = ff[STAGES-1];

    a_sync_delay: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(rst_n, 2) && $past(rst_n) |-> q == $past(d, STAGES))
        else $error("standby input not delayed by the sync stages");

endmodule // dcs_sync
